// ===== rtl/pmic_cmd_status_regs.sv
// Command and status register group behind the I2C target port
// Contract
// [RQ1] Writing one to bit 2 starts the NVM read; bit 3 shows busy.
// [RQ2] Host polls busy until low before collecting the fetched byte.
// [RQ3] Host writes zero to all reserved bits.
// [RQ4] Command bit 7 triggers exactly one supply-voltage conversion.
// [RQ5] Host disables auto sampling and clears results before single conversion.
// [RQ6] Command bit 6 makes next conversion preload all three result registers.
// [RQ7] Command bit 5 clears every charge counter at once.
// [RQ8] Command bit 4 starts charge counter calibration.
// [RQ9] Command bit 2 rereads NVM, restoring control registers to defaults.
// [RQ10] Command bit 0 forces full device reset like a brownout.
// [RQ11] Single-cell flag latched at power-on from the aux supply pin.
// [RQ12] Bit 2 of mode register: 0 buck switching, 1 linear regulation.
// [RQ13] Mode register does not update while the host addresses it.
// [RQ14] Host addresses mode register only to read it; recomputes charge per pulse.
// [RQ15] Converter mode held constant during a calibration run.
// [RQ16] NVM read uses the 7-bit address field at bits 6:0.
// [RQ17] Fetched byte appears in the read-data register, reset zero.
// [RQ18] Command bits are one-cycle strobes; command register reads zero.
// [RQ19] Read trigger self-clears at completion; ignored while busy.
`timescale 1ns/1ns
`default_nettype none
`include "pmic_cfg.svh"
module pmic_cmd_status_regs
    import pmic_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `I2C_DEV_ADDR
)(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       aux_supply_pin,
    input  wire logic       second_converter_state,
    input  wire logic       adc_conv_done,
    input  wire logic       cal_done,
    input  wire logic       nvm_mem_ack,
    input  wire logic [7:0] nvm_mem_data,
    output logic            nvm_mem_req,
    output logic [6:0]      nvm_mem_addr,
    output logic            adc_start,
    output logic            adc_preload_armed,
    output logic            charge_tally_wipe,
    output logic            charge_cal_go,
    output logic            nvm_defaults_reload,
    output logic            full_reset_req,
    output logic            mode_hold
);
    // Async inputs: scl, sda, aux pin, converter state
    localparam int NSYNC = 4;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] s1_reg;
    logic [NSYNC-1:0] s2_reg;
    logic [NSYNC-1:0] s3_reg;
    logic [NSYNC-1:0] filt_reg;
    logic             scl_prev_reg;
    logic             sda_prev_reg;

    assign async_in = {second_converter_state, aux_supply_pin, sda_in, scl_in};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    s1_reg[gi]   <= 1'b1;
                    s2_reg[gi]   <= 1'b1;
                    s3_reg[gi]   <= 1'b1;
                    filt_reg[gi] <= 1'b1;
                end else begin
                    s1_reg[gi] <= async_in[gi];
                    s2_reg[gi] <= s1_reg[gi];
                    s3_reg[gi] <= s2_reg[gi];
                    // A change counts only once two stages agree
                    if (s2_reg[gi] == s3_reg[gi]) begin
                        filt_reg[gi] <= s3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    logic scl_f;
    logic sda_f;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_f     = filt_reg[0];
    assign sda_f     = filt_reg[1];
    assign scl_rise  = scl_f && !scl_prev_reg;
    assign scl_fall  = !scl_f && scl_prev_reg;
    assign bus_start = scl_f && scl_prev_reg && sda_prev_reg && !sda_f;
    assign bus_stop  = scl_f && scl_prev_reg && !sda_prev_reg && sda_f;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_f;
            sda_prev_reg <= sda_f;
        end
    end

    // I2C target engine
    bus_state_e bus_reg;
    logic [3:0] bit_reg;
    logic       in_ack_reg;
    logic [7:0] shift_reg;
    logic [7:0] ptr_reg;
    logic       busy_bus_reg;
    reg_wr_s    wr_reg;
    logic [7:0] rd_byte;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bus_reg      <= BUS_IDLE;
            bit_reg      <= 4'h0;
            in_ack_reg   <= 1'b0;
            shift_reg    <= 8'h00;
            ptr_reg      <= 8'h00;
            busy_bus_reg <= 1'b0;
            sda_oe       <= 1'b0;
            wr_reg       <= '0;
        end else begin
            wr_reg.stb <= 1'b0;
            if (bus_start) begin
                bus_reg      <= BUS_ADDR;
                bit_reg      <= 4'h0;
                in_ack_reg   <= 1'b0;
                busy_bus_reg <= 1'b1;
                sda_oe       <= 1'b0;
            end else if (bus_stop) begin
                bus_reg      <= BUS_IDLE;
                busy_bus_reg <= 1'b0;
                sda_oe       <= 1'b0;
            end else if (bus_reg != BUS_IDLE && scl_rise) begin
                if (in_ack_reg) begin
                    // Controller NACK ends a read
                    if (bus_reg == BUS_RD && sda_f) begin
                        bus_reg <= BUS_IDLE;
                    end
                end else begin
                    if (bus_reg != BUS_RD) begin
                        shift_reg <= {shift_reg[6:0], sda_f};
                    end
                    bit_reg <= bit_reg + 4'h1;
                end
            end else if (bus_reg != BUS_IDLE && scl_fall) begin
                if (in_ack_reg) begin
                    in_ack_reg <= 1'b0;
                    bit_reg    <= 4'h0;
                    sda_oe     <= 1'b0;
                    if (bus_reg == BUS_ADDR) begin
                        bus_reg <= shift_reg[0] ? BUS_RD : BUS_PTR;
                    end else if (bus_reg == BUS_PTR) begin
                        bus_reg <= BUS_WR;
                    end
                    if ((bus_reg == BUS_ADDR && shift_reg[0]) || bus_reg == BUS_RD) begin
                        shift_reg <= rd_byte;
                        sda_oe    <= !rd_byte[7];
                        ptr_reg   <= ptr_reg + 8'h01;
                    end
                end else if (bit_reg == 4'h8) begin
                    in_ack_reg <= 1'b1;
                    unique case (bus_reg)
                        BUS_ADDR: begin
                            if (shift_reg[7:1] == DEV_ADDR) begin
                                sda_oe <= 1'b1;
                            end else begin
                                bus_reg <= BUS_IDLE;
                            end
                        end
                        BUS_PTR: begin
                            ptr_reg <= shift_reg;
                            sda_oe  <= 1'b1;
                        end
                        BUS_WR: begin
                            wr_reg  <= '{stb: 1'b1, addr: ptr_reg, data: shift_reg};
                            ptr_reg <= ptr_reg + 8'h01;
                            sda_oe  <= 1'b1;
                        end
                        default: begin
                            sda_oe <= 1'b0;
                        end
                    endcase
                end else if (bus_reg == BUS_RD) begin
                    shift_reg <= {shift_reg[6:0], 1'b0};
                    sda_oe    <= !shift_reg[6];
                end
            end
        end
    end

    // Open drain: only ever pulls low
    always_ff @(posedge ref_clk) begin
        sda_out <= 1'b0;
    end

    // Register state
    logic [6:0] nvm_addr_reg;
    logic [7:0] nvm_rdata;
    logic       nvm_busy;
    logic       nvm_start_reg;
    logic       sc_flag_reg;
    logic       sc_done_reg;
    logic [1:0] settle_reg;
    logic       conv_state_reg;
    logic       mode_frozen;

    assign mode_frozen = busy_bus_reg && ptr_reg == `MODE_OFF; // [RQ13]

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            nvm_addr_reg  <= 7'h00;
            nvm_start_reg <= 1'b0;
        end else begin
            nvm_start_reg <= 1'b0;
            if (nvm_defaults_reload) begin
                nvm_addr_reg <= 7'h00; // [RQ9]
            end else if (wr_reg.stb && wr_reg.addr == `NVM_ADDR_OFF) begin
                nvm_addr_reg <= wr_reg.data[6:0]; // [RQ16]
            end
            if (wr_reg.stb && wr_reg.addr == `NVM_STATCTL_OFF
                    && wr_reg.data[`NVM_TRIG_BIT] && !nvm_busy) begin
                nvm_start_reg <= 1'b1; // [RQ1] [RQ19]
            end
        end
    end

    // Command strobes: pulses only, nothing held [RQ18]
    logic cmd_wr;
    assign cmd_wr = wr_reg.stb && wr_reg.addr == `CMD_OFF;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            adc_start           <= 1'b0;
            charge_tally_wipe   <= 1'b0;
            charge_cal_go       <= 1'b0;
            nvm_defaults_reload <= 1'b0;
            full_reset_req      <= 1'b0;
        end else begin
            adc_start           <= cmd_wr && wr_reg.data[`CMD_ADC_START]; // [RQ4]
            charge_tally_wipe   <= cmd_wr && wr_reg.data[`CMD_TALLY_WIPE]; // [RQ7]
            charge_cal_go       <= cmd_wr && wr_reg.data[`CMD_CAL_GO]; // [RQ8]
            nvm_defaults_reload <= cmd_wr && wr_reg.data[`CMD_RELOAD]; // [RQ9]
            full_reset_req      <= cmd_wr && wr_reg.data[`CMD_FULL_RESET]; // [RQ10]
        end
    end

    // Set wins over clear on both armed levels
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            adc_preload_armed <= 1'b0;
            mode_hold         <= 1'b0;
        end else begin
            if (cmd_wr && wr_reg.data[`CMD_ADC_PRELOAD]) begin
                adc_preload_armed <= 1'b1; // [RQ6]
            end else if (adc_conv_done) begin
                adc_preload_armed <= 1'b0;
            end
            if (cmd_wr && wr_reg.data[`CMD_CAL_GO]) begin
                mode_hold <= 1'b1; // [RQ15]
            end else if (cal_done) begin
                mode_hold <= 1'b0;
            end
        end
    end

    // Strap caught once the synchroniser has settled
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            settle_reg     <= 2'h0;
            sc_done_reg    <= 1'b0;
            sc_flag_reg    <= 1'b0;
            conv_state_reg <= 1'b0;
        end else begin
            if (settle_reg != `SETTLE_CYCLES) begin
                settle_reg <= settle_reg + 2'h1;
            end else if (!sc_done_reg) begin
                sc_done_reg <= 1'b1;
                // Filter's next value, so a pin held low from reset is not missed
                sc_flag_reg <= (s2_reg[2] == s3_reg[2]) ? s3_reg[2] : filt_reg[2]; // [RQ11]
            end
            // Frozen while addressed; also frozen during calibration upstream
            if (!mode_frozen) begin
                conv_state_reg <= filt_reg[3]; // [RQ12] [RQ13]
            end
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        unique case (ptr_reg)
            `NVM_ADDR_OFF:    rd_byte = {1'b0, nvm_addr_reg};
            `NVM_RDATA_OFF:   rd_byte = nvm_rdata; // [RQ17]
            `NVM_STATCTL_OFF: begin
                rd_byte[`NVM_BUSY_BIT] = nvm_busy; // [RQ1]
                rd_byte[`NVM_TRIG_BIT] = nvm_busy; // [RQ19]
            end
            `MODE_OFF: begin
                rd_byte[`MODE_SC_BIT]   = sc_flag_reg;
                rd_byte[`MODE_CONV_BIT] = conv_state_reg;
            end
            default: rd_byte = 8'h00; // [RQ18]
        endcase
    end

    nvm_read_seq u_nvm (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .start    (nvm_start_reg),
        .addr     (nvm_addr_reg),
        .mem_ack  (nvm_mem_ack),
        .mem_data (nvm_mem_data),
        .mem_req  (nvm_mem_req),
        .mem_addr (nvm_mem_addr),
        .busy     (nvm_busy),
        .rdata    (nvm_rdata)
    );
endmodule // pmic_cmd_status_regs
`default_nettype wire

// ===== shared/pmic_cfg.svh
// Register offsets, field positions, reset values and bus constants
`ifndef PMIC_CFG_SVH
`define PMIC_CFG_SVH
`define NVM_ADDR_OFF     8'h0B
`define NVM_RDATA_OFF    8'h0C
`define NVM_STATCTL_OFF  8'h0E
`define CMD_OFF          8'h10
`define MODE_OFF         8'h12
`define NVM_TRIG_BIT     2
`define NVM_BUSY_BIT     3
`define CMD_ADC_START    7
`define CMD_ADC_PRELOAD  6
`define CMD_TALLY_WIPE   5
`define CMD_CAL_GO       4
`define CMD_RELOAD       2
`define CMD_FULL_RESET   0
`define MODE_SC_BIT      3
`define MODE_CONV_BIT    2
`define REG_RESET        8'h00
`define I2C_DEV_ADDR     7'h2A
`define SETTLE_CYCLES    2'h3
`endif

// ===== shared/pmic_pkg.sv
// Shared types for the command and status register group
package pmic_pkg;
    typedef struct packed {
        logic       stb;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_s;

    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_PTR,
        BUS_WR,
        BUS_RD
    } bus_state_e;

    typedef enum logic [1:0] {
        NVM_IDLE,
        NVM_REQ,
        NVM_WAIT
    } nvm_state_e;
endpackage

// ===== rtl/nvm_read_seq.sv
// Nonvolatile memory read sequencer
`timescale 1ns/1ns
`default_nettype none
`include "pmic_cfg.svh"
module nvm_read_seq
    import pmic_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic [6:0] addr,
    input  wire logic       mem_ack,
    input  wire logic [7:0] mem_data,
    output logic            mem_req,
    output logic [6:0]      mem_addr,
    output logic            busy,
    output logic [7:0]      rdata
);
    nvm_state_e state_reg;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= NVM_IDLE;
            mem_req   <= 1'b0;
            mem_addr  <= 7'h00;
            busy      <= 1'b0;
            rdata     <= `REG_RESET;
        end else begin
            unique case (state_reg)
                NVM_IDLE: begin
                    // Start while busy never reaches here [RQ19]
                    if (start) begin
                        mem_addr  <= addr; // [RQ16]
                        mem_req   <= 1'b1;
                        busy      <= 1'b1; // [RQ1]
                        state_reg <= NVM_REQ;
                    end
                end
                NVM_REQ: begin
                    mem_req   <= 1'b0;
                    state_reg <= NVM_WAIT;
                end
                NVM_WAIT: begin
                    if (mem_ack) begin
                        rdata     <= mem_data; // [RQ17]
                        busy      <= 1'b0; // [RQ1]
                        state_reg <= NVM_IDLE;
                    end
                end
            endcase
        end
    end
endmodule // nvm_read_seq
`default_nettype wire

// ===== dv/pmic_cmd_status_regs_props.sv
// Concurrent checks on the command and status register group
`timescale 1ns/1ns
`default_nettype none
module pmic_cmd_status_regs_props (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       nvm_mem_req,
    input wire logic       nvm_mem_ack,
    input wire logic [6:0] nvm_mem_addr,
    input wire logic       adc_start,
    input wire logic       adc_preload_armed,
    input wire logic       adc_conv_done,
    input wire logic       charge_tally_wipe,
    input wire logic       charge_cal_go,
    input wire logic       cal_done,
    input wire logic       mode_hold,
    input wire logic       nvm_defaults_reload,
    input wire logic       full_reset_req
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Fetch in flight until the memory answers
    logic pend_reg;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || nvm_mem_ack) begin
            pend_reg <= 1'b0;
        end else if (nvm_mem_req) begin
            pend_reg <= 1'b1;
        end
    end

    sequence cal_start_s;
        charge_cal_go;
    endsequence
    sequence fetch_s;
        nvm_mem_req;
    endsequence
    property one_shot_p(sig);
        sig |=> !sig;
    endproperty

    adc_pulse_a: assert property (one_shot_p(adc_start))
        else $error("adc start wider than one cycle");
    wipe_pulse_a: assert property (one_shot_p(charge_tally_wipe))
        else $error("tally wipe wider than one cycle");
    reload_pulse_a: assert property (one_shot_p(nvm_defaults_reload))
        else $error("reload wider than one cycle");
    reset_pulse_a: assert property (one_shot_p(full_reset_req))
        else $error("full reset request wider than one cycle");
    req_single_a: assert property (fetch_s |-> !pend_reg ##1 !nvm_mem_req)
        else $error("second fetch before the answer");
    req_addr_a: assert property (fetch_s |=> $stable(nvm_mem_addr) [*3])
        else $error("fetch address moved while pending");
    preload_keep_a: assert property (adc_preload_armed && !adc_conv_done |=> adc_preload_armed)
        else $error("preload dropped without a conversion");
    preload_drop_a: assert property (adc_preload_armed && adc_conv_done |=> !adc_preload_armed)
        else $error("preload kept after a conversion");
    cal_hold_a: assert property (cal_start_s |-> ##[0:1] mode_hold)
        else $error("calibration start without mode hold");
    hold_keep_a: assert property (mode_hold && !cal_done |=> mode_hold)
        else $error("mode hold released during calibration");
endmodule // pmic_cmd_status_regs_props
`default_nettype wire

// ===== dv/i2c_host_model.sv
// Behavioural I2C host that reaches the register group
`timescale 1ns/1ns
`default_nettype none
`include "pmic_cfg.svh"
module i2c_host_model (
    input  wire logic ref_clk,
    input  wire logic sda_oe,
    output var logic  scl,
    output var logic  sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // One ref_clk period, an eighth of the 80 ns link period
    task automatic q(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Slow edges so the filtered SDA settles well before the filtered SCL moves
    task automatic start;
        sda_drv = 1'b1;
        q(4);
        scl = 1'b1;
        q(4);
        sda_drv = 1'b0;
        q(4);
        scl = 1'b0;
        q(2);
    endtask
    task automatic stop;
        sda_drv = 1'b0;
        q(4);
        scl = 1'b1;
        q(4);
        sda_drv = 1'b1;
        q(4);
    endtask
    // Long low phase: the filtered target moves SDA some 45 ns after SCL falls,
    // which must not land in the filtered high phase and look like START or STOP
    task automatic bitx(input logic b, output logic r);
        sda_drv = b;
        q(4);
        scl = 1'b1;
        q(2);
        r = sda_drv & ~sda_oe;
        scl = 1'b0;
        q(2);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
        bitx(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, d[i]);
        end
        bitx(last, r);
    endtask
    task automatic wr_reg(input logic [7:0] off, input logic [7:0] data, output logic ok);
        logic a0, a1, a2;
        start();
        wbyte({`I2C_DEV_ADDR, 1'b0}, a0);
        wbyte(off, a1);
        wbyte(data, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    // Pointer and read in one transfer, so a frozen register is never left addressed
    task automatic rd_reg(input logic [7:0] off, output logic [7:0] data);
        logic a;
        start();
        wbyte({`I2C_DEV_ADDR, 1'b0}, a);
        wbyte(off, a);
        start();
        wbyte({`I2C_DEV_ADDR, 1'b1}, a);
        rbyte(1'b1, data);
        stop();
    endtask
endmodule // i2c_host_model
`default_nettype wire

// ===== dv/pmic_cmd_status_regs_tb.sv
// Self-checking bench for the command and status register group
`timescale 1ns/1ns
`default_nettype none
`include "pmic_cfg.svh"
module pmic_cmd_status_regs_tb;
    logic       ref_clk = 1'b0;
    logic       rst_n, scl, host_sda, sda_out, sda_oe, ack;
    logic       aux_supply_pin, second_converter_state, adc_conv_done, cal_done;
    logic       nvm_mem_ack, nvm_mem_req, adc_start, adc_preload_armed, charge_tally_wipe;
    logic       charge_cal_go, nvm_defaults_reload, full_reset_req, mode_hold;
    logic [7:0] nvm_mem_data, rd_d, req_cnt;
    logic [6:0] nvm_mem_addr, got_addr;
    logic [7:0] pc [5];
    int         error_cnt = 0;
    int         checks = 0;
    logic       pc_clr = 1'b0;
    wire  [4:0] strb = {full_reset_req, nvm_defaults_reload, charge_cal_go,
                        charge_tally_wipe, adc_start};
    wire        sda_line = host_sda & ~sda_oe;
    localparam logic [7:0] BITV [5] = '{8'h80, 8'h20, 8'h10, 8'h04, 8'h01};

    always #5 ref_clk = ~ref_clk;

    pmic_cmd_status_regs uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .aux_supply_pin(aux_supply_pin),
        .second_converter_state(second_converter_state), .adc_conv_done(adc_conv_done),
        .cal_done(cal_done), .nvm_mem_ack(nvm_mem_ack), .nvm_mem_data(nvm_mem_data),
        .nvm_mem_req(nvm_mem_req), .nvm_mem_addr(nvm_mem_addr), .adc_start(adc_start),
        .adc_preload_armed(adc_preload_armed), .charge_tally_wipe(charge_tally_wipe),
        .charge_cal_go(charge_cal_go), .nvm_defaults_reload(nvm_defaults_reload),
        .full_reset_req(full_reset_req), .mode_hold(mode_hold)
    );
    i2c_host_model host (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda_drv(host_sda));

    always @(posedge ref_clk) begin
        for (int k = 0; k < 5; k++) begin
            pc[k] <= pc_clr ? 8'h00 : pc[k] + 8'(strb[k]);
        end
        req_cnt <= rst_n ? req_cnt + 8'(nvm_mem_req) : 8'h00;
    end

    // Slow memory, so busy is still seen after a full register read
    initial forever begin
        @(negedge ref_clk);
        if (nvm_mem_req === 1'b1) begin
            got_addr = nvm_mem_addr;
            repeat (800) @(negedge ref_clk);
            nvm_mem_data = {1'b1, got_addr} ^ 8'h5A;
            nvm_mem_ack = 1'b1;
            @(negedge ref_clk);
            nvm_mem_ack = 1'b0;
            nvm_mem_data = ~nvm_mem_data;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        host.wr_reg(a, d, ok);
        chk({7'h00, ok}, 8'h01);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd_reg(a, d);
        chk(d, exp);
    endtask
    task automatic blip(ref logic s);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic test_done;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        error_cnt++;
        test_done();
    end

    initial begin
        rst_n = 1'b0;
        aux_supply_pin = 1'b1;
        second_converter_state = 1'b0;
        adc_conv_done = 1'b0;
        cal_done = 1'b0;
        nvm_mem_ack = 1'b0;
        nvm_mem_data = 8'h00;
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (10) @(negedge ref_clk);
        rdchk(8'h0E, 8'h00);
        rdchk(8'h0C, 8'h00);
        rdchk(8'h12, 8'h08);
        wr(8'h20, 8'hFF);
        rdchk(8'h20, 8'h00);
        host.start();
        host.wbyte({~`I2C_DEV_ADDR, 1'b0}, ack);
        host.stop();
        chk({7'h00, ack}, 8'h00);
        wr(8'h0B, 8'h55);
        rdchk(8'h0B, 8'h55);
        for (int i = 0; i < 5; i++) begin
            pc_clr = 1'b1;
            @(negedge ref_clk);
            pc_clr = 1'b0;
            wr(8'h10, BITV[i]);
            repeat (20) @(negedge ref_clk);
            for (int j = 0; j < 5; j++) begin
                chk(pc[j], 8'(i == j));
            end
        end
        rdchk(8'h0B, 8'h00);
        rdchk(8'h10, 8'h00);
        chk({7'h00, mode_hold}, 8'h01);
        blip(cal_done);
        chk({7'h00, mode_hold}, 8'h00);
        wr(8'h10, 8'h40);
        chk({7'h00, adc_preload_armed}, 8'h01);
        blip(adc_conv_done);
        chk({7'h00, adc_preload_armed}, 8'h00);
        wr(8'h0B, 8'h7F);
        wr(8'h0E, 8'h04);
        rdchk(8'h0E, 8'h0C);
        wr(8'h0E, 8'h04);
        rd_d = 8'hFF;
        for (int n = 0; n < 20 && rd_d[3] !== 1'b0; n++) begin
            host.rd_reg(8'h0E, rd_d);
        end
        chk(rd_d, 8'h00);
        chk(req_cnt, 8'h01);
        chk({1'b0, got_addr}, 8'h7F);
        rdchk(8'h0C, 8'hA5);
        fork
            rdchk(8'h12, 8'h08);
            begin
                repeat (200) @(negedge ref_clk);
                second_converter_state = 1'b1;
            end
        join
        rdchk(8'h12, 8'h0C);
        chk({7'h00, sda_out}, 8'h00);
        // Second power-up with the aux pin low
        aux_supply_pin = 1'b0;
        rst_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (10) @(negedge ref_clk);
        rdchk(8'h12, 8'h04);
        rdchk(8'h0B, 8'h00);
        test_done();
    end
endmodule // pmic_cmd_status_regs_tb

bind pmic_cmd_status_regs pmic_cmd_status_regs_props chk_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .nvm_mem_req(nvm_mem_req), .nvm_mem_ack(nvm_mem_ack),
    .nvm_mem_addr(nvm_mem_addr), .adc_start(adc_start), .adc_preload_armed(adc_preload_armed),
    .adc_conv_done(adc_conv_done), .charge_tally_wipe(charge_tally_wipe),
    .charge_cal_go(charge_cal_go), .cal_done(cal_done), .mode_hold(mode_hold),
    .nvm_defaults_reload(nvm_defaults_reload), .full_reset_req(full_reset_req)
);
`default_nettype wire
